// File: core/lsc_pkg.sv
// Function
// - Running totals of accepted frames and octets
// - Received frame/octet counts over last minute
// - Count frames with bit count not byte-aligned
// - Seven-plus ones abort counts exactly once
// - Count received frames failing checksum check
// - Count received frames outside length bounds
// - Count received frames dropped, no buffer
// - Count frames evicted from each direction's queue
// - Transmit frame/octet totals and minute window
// - Count transmit frames dropped for underrun
// - Present and peak occupancy per transmit queue
// - Ethernet all, good, broadcast, multicast receive counts
// - Good frames under 64 bytes: undersize
// - Good frames above configured maximum: oversize
// - Bad checksum under 64 bytes: fragment
// - Bad checksum above configured maximum: jabber
// - Count every bad-checksum received frame
// - Count frames dropped for lack of buffer
// - Count frames dropped for unknown VLAN
// - Ethernet good transmit frames, octets, broadcast, multicast
// - Count collisions during transmission
// - Frames from 64 bytes to the configured maximum land in one of six length bins
package lsc_pkg;
    localparam int CW = 32;
    typedef logic [CW-1:0] lsc_ctr_t;
    localparam int ETH_PORTS = 2;
    // Uplink counter indices
    localparam int H_RX_FRM = 0;
    localparam int H_RX_OCT = 1;
    localparam int H_RX_LEN = 2;
    localparam int H_RX_NOB = 3;
    localparam int H_RX_ABT = 4;
    localparam int H_RX_FCS = 5;
    localparam int H_RX_OVR = 6;
    localparam int H_RX_EVI = 7;
    localparam int H_TX_FRM = 8;
    localparam int H_TX_OCT = 9;
    localparam int H_TX_UND = 10;
    localparam int H_TX_EVI = 11;
    localparam int H_NCTR = 12;
    // Ethernet counter indices, relative to the port base
    localparam int E_RX_FRM = 0;
    localparam int E_RX_OCT = 1;
    localparam int E_RX_GFRM = 2;
    localparam int E_RX_GOCT = 3;
    localparam int E_RX_BC = 4;
    localparam int E_RX_MC = 5;
    localparam int E_RX_UND = 6;
    localparam int E_RX_OVS = 7;
    localparam int E_RX_FRAG = 8;
    localparam int E_RX_JAB = 9;
    localparam int E_RX_FCS = 10;
    localparam int E_RX_DISC = 11;
    localparam int E_RX_FILT = 12;
    localparam int E_TX_FRM = 13;
    localparam int E_TX_OCT = 14;
    localparam int E_TX_BC = 15;
    localparam int E_TX_MC = 16;
    localparam int E_TX_COL = 17;
    localparam int E_HIST0 = 18;
    localparam int HIST_BINS = 6;
    localparam int E_NCTR = 24;
    localparam int NCTR = H_NCTR + ETH_PORTS * E_NCTR;
    // Minute window
    localparam int W_RX_FRM = 0;
    localparam int W_RX_OCT = 1;
    localparam int W_TX_FRM = 2;
    localparam int W_TX_OCT = 3;
    localparam int W_N = 4;
    localparam int PTR_W = 6;
    localparam logic [PTR_W-1:0] WIN_SECONDS = 6'h3C;
    localparam logic [PTR_W-1:0] PTR_LAST = WIN_SECONDS - 6'h01;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SLOT_NS = 32'h3B9A_CA00;
    localparam int TICK_CYCLES = SLOT_NS / CLK_PERIOD_NS;
    // Frame length thresholds in bytes
    localparam logic [15:0] LEN_64 = 16'h0040;
    localparam logic [15:0] LEN_128 = 16'h0080;
    localparam logic [15:0] LEN_256 = 16'h0100;
    localparam logic [15:0] LEN_512 = 16'h0200;
    localparam logic [15:0] LEN_1024 = 16'h0400;
    // Transmit queues
    localparam int NQ = 3;
    localparam int Q_VOICE = 0;
    localparam int Q_DATA = 1;
    localparam int Q_MGMT = 2;
    localparam int QW = 16;
    typedef struct packed {
        logic done;
        logic [18:0] bits;
        logic fcs_bad;
        logic no_buf;
        logic abort;
        logic evict;
    } lsc_hdlc_rx_t;
    typedef struct packed {
        logic done;
        logic [15:0] octets;
        logic underrun;
        logic evict;
        logic [NQ-1:0] enq;
        logic [NQ-1:0] deq;
    } lsc_hdlc_tx_t;
    typedef struct packed {
        logic done;
        logic [15:0] len;
        logic fcs_bad;
        logic bcast;
        logic mcast;
        logic no_buf;
        logic vlan_unknown;
    } lsc_eth_rx_t;
    typedef struct packed {
        logic done;
        logic [15:0] len;
        logic bcast;
        logic mcast;
        logic collision;
    } lsc_eth_tx_t;
    typedef struct packed {
        logic [QW-1:0] level;
        logic [QW-1:0] peak;
    } lsc_q_t;

    function automatic lsc_ctr_t lsc_sat_add(lsc_ctr_t a, lsc_ctr_t b);
        logic [CW:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[CW] ? '1 : s[CW-1:0];
    endfunction : lsc_sat_add

    function automatic logic [HIST_BINS-1:0] lsc_len_bin(logic [15:0] len, logic [15:0] mx);
        logic [HIST_BINS-1:0] b;
        b = '0;
        if (len == LEN_64) begin
            b[0] = 1'b1;
        end else if (len > LEN_64 && len < LEN_128) begin
            b[1] = 1'b1;
        end else if (len >= LEN_128 && len < LEN_256) begin
            b[2] = 1'b1;
        end else if (len >= LEN_256 && len < LEN_512) begin
            b[3] = 1'b1;
        end else if (len >= LEN_512 && len < LEN_1024) begin
            b[4] = 1'b1;
        end else if (len >= LEN_1024 && len <= mx) begin
            b[5] = 1'b1;
        end
        return b;
    endfunction : lsc_len_bin
endpackage : lsc_pkg

// File: core/lsc_ring_mem.sv
`timescale 1ns/1ns
module lsc_ring_mem #(
    parameter int W = 128,
    parameter int AW = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read side
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    // Contents are not reset; the owner keeps per-slot valid bits
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : lsc_ring_mem

// File: core/lsc_qlevel.sv
`timescale 1ns/1ns
module lsc_qlevel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Queue events
    input wire logic clear,
    input wire logic enq,
    input wire logic deq,
    // Occupancy
    output logic [lsc_pkg::QW-1:0] level,
    output logic [lsc_pkg::QW-1:0] peak
);
    lsc_pkg::lsc_q_t st_r;
    lsc_pkg::lsc_q_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (enq && !deq && st_r.level != '1) begin
            st_nxt.level = st_r.level + 16'h0001;
        end else if (deq && !enq && st_r.level != '0) begin
            st_nxt.level = st_r.level - 16'h0001;
        end
        // Peak restarts from zero and catches up with the level next cycle
        if (clear) begin
            st_nxt.peak = '0;
        end else if (st_nxt.level > st_r.peak) begin
            st_nxt.peak = st_nxt.level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.level;
    assign peak = st_r.peak;

    AST_PEAK_COVERS_LEVEL: assert property (@(posedge clk) disable iff (rst)
        (!clear) |=> (peak >= level))
        else $error("Queue peak below present level");
endmodule : lsc_qlevel

// File: core/lsc_link_stats.sv
`timescale 1ns/1ns
module lsc_link_stats #(
    parameter int TICK_CYCLES = lsc_pkg::TICK_CYCLES,
    parameter logic [15:0] HDLC_MIN_OCT = 16'h0004,
    parameter logic [15:0] HDLC_MAX_OCT = 16'h0640
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software command
    input wire logic clear_all,
    // Uplink framer events
    input wire lsc_pkg::lsc_hdlc_rx_t hdlc_rx,
    input wire lsc_pkg::lsc_hdlc_tx_t hdlc_tx,
    // Ethernet MAC events
    input wire lsc_pkg::lsc_eth_rx_t [lsc_pkg::ETH_PORTS-1:0] eth_rx,
    input wire lsc_pkg::lsc_eth_tx_t [lsc_pkg::ETH_PORTS-1:0] eth_tx,
    input wire logic [15:0] max_frame_length_limit,
    // Counter values
    output lsc_pkg::lsc_ctr_t [lsc_pkg::NCTR-1:0] counters,
    output lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] window_counts,
    output logic [lsc_pkg::NQ-1:0][lsc_pkg::QW-1:0] queue_present_level,
    output logic [lsc_pkg::NQ-1:0][lsc_pkg::QW-1:0] queue_peak_level
);
    localparam int MW = lsc_pkg::CW * lsc_pkg::W_N;
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    typedef struct packed {
        lsc_pkg::lsc_ctr_t [lsc_pkg::NCTR-1:0] cnt;
        lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] win;
        lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] bucket;
        logic [31:0] sec_cnt;
        logic [lsc_pkg::PTR_W-1:0] ptr;
        logic [63:0] slot_vld;
        logic abort_d;
    } lsc_main_t;

    lsc_main_t st_r;
    lsc_main_t st_nxt;
    lsc_pkg::lsc_ctr_t [lsc_pkg::NCTR-1:0] inc;
    lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] win_add;
    lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] old_slot;
    logic [MW-1:0] ring_rdata;
    logic tick;

    // Uplink receive frame classification
    logic [15:0] rx_oct;
    logic rx_nob;
    logic rx_len_bad;
    logic rx_good;
    logic rx_abort_rise;
    logic tx_good;

    assign rx_oct = hdlc_rx.bits[18:3];
    assign rx_nob = hdlc_rx.done && (hdlc_rx.bits[2:0] != 3'h0);
    assign rx_len_bad = hdlc_rx.done
        && (rx_oct < HDLC_MIN_OCT || rx_oct > HDLC_MAX_OCT);
    // Only clean frames that found a buffer are accepted
    assign rx_good = hdlc_rx.done && !hdlc_rx.fcs_bad && !rx_nob
        && !rx_len_bad && !hdlc_rx.no_buf;
    // Abort may be held for many cycles; one count per run of ones
    assign rx_abort_rise = hdlc_rx.abort && !st_r.abort_d;
    assign tx_good = hdlc_tx.done && !hdlc_tx.underrun;

    assign inc[lsc_pkg::H_RX_FRM] = lsc_pkg::lsc_ctr_t'(rx_good);
    assign inc[lsc_pkg::H_RX_OCT] = rx_good ? lsc_pkg::lsc_ctr_t'(rx_oct) : '0;
    assign inc[lsc_pkg::H_RX_LEN] = lsc_pkg::lsc_ctr_t'(rx_len_bad);
    assign inc[lsc_pkg::H_RX_NOB] = lsc_pkg::lsc_ctr_t'(rx_nob);
    assign inc[lsc_pkg::H_RX_ABT] = lsc_pkg::lsc_ctr_t'(rx_abort_rise);
    assign inc[lsc_pkg::H_RX_FCS] =
        lsc_pkg::lsc_ctr_t'(hdlc_rx.done && hdlc_rx.fcs_bad);
    assign inc[lsc_pkg::H_RX_OVR] =
        lsc_pkg::lsc_ctr_t'(hdlc_rx.done && hdlc_rx.no_buf);
    assign inc[lsc_pkg::H_RX_EVI] = lsc_pkg::lsc_ctr_t'(hdlc_rx.evict);
    assign inc[lsc_pkg::H_TX_FRM] = lsc_pkg::lsc_ctr_t'(tx_good);
    assign inc[lsc_pkg::H_TX_OCT] =
        tx_good ? lsc_pkg::lsc_ctr_t'(hdlc_tx.octets) : '0;
    assign inc[lsc_pkg::H_TX_UND] =
        lsc_pkg::lsc_ctr_t'(hdlc_tx.done && hdlc_tx.underrun);
    assign inc[lsc_pkg::H_TX_EVI] = lsc_pkg::lsc_ctr_t'(hdlc_tx.evict);

    assign win_add[lsc_pkg::W_RX_FRM] = inc[lsc_pkg::H_RX_FRM];
    assign win_add[lsc_pkg::W_RX_OCT] = inc[lsc_pkg::H_RX_OCT];
    assign win_add[lsc_pkg::W_TX_FRM] = inc[lsc_pkg::H_TX_FRM];
    assign win_add[lsc_pkg::W_TX_OCT] = inc[lsc_pkg::H_TX_OCT];

    // Ethernet classification, one block per port
    for (genvar p = 0; p < lsc_pkg::ETH_PORTS; p++) begin : g_eth
        localparam int B = lsc_pkg::H_NCTR + p * lsc_pkg::E_NCTR;
        logic good;
        logic tgood;
        logic short_frm;
        logic big;
        logic [lsc_pkg::HIST_BINS-1:0] rx_bin;
        logic [lsc_pkg::HIST_BINS-1:0] tx_bin;
        assign good = eth_rx[p].done && !eth_rx[p].fcs_bad;
        assign tgood = eth_tx[p].done;
        assign short_frm = eth_rx[p].len < lsc_pkg::LEN_64;
        assign big = eth_rx[p].len > max_frame_length_limit;
        assign inc[B + lsc_pkg::E_RX_FRM] = lsc_pkg::lsc_ctr_t'(eth_rx[p].done);
        assign inc[B + lsc_pkg::E_RX_OCT] =
            eth_rx[p].done ? lsc_pkg::lsc_ctr_t'(eth_rx[p].len) : '0;
        assign inc[B + lsc_pkg::E_RX_GFRM] = lsc_pkg::lsc_ctr_t'(good);
        assign inc[B + lsc_pkg::E_RX_GOCT] =
            good ? lsc_pkg::lsc_ctr_t'(eth_rx[p].len) : '0;
        assign inc[B + lsc_pkg::E_RX_BC] =
            lsc_pkg::lsc_ctr_t'(good && eth_rx[p].bcast);
        assign inc[B + lsc_pkg::E_RX_MC] =
            lsc_pkg::lsc_ctr_t'(good && eth_rx[p].mcast);
        assign inc[B + lsc_pkg::E_RX_UND] = lsc_pkg::lsc_ctr_t'(good && short_frm);
        assign inc[B + lsc_pkg::E_RX_OVS] = lsc_pkg::lsc_ctr_t'(good && big);
        assign inc[B + lsc_pkg::E_RX_FRAG] =
            lsc_pkg::lsc_ctr_t'(eth_rx[p].done && eth_rx[p].fcs_bad && short_frm);
        assign inc[B + lsc_pkg::E_RX_JAB] =
            lsc_pkg::lsc_ctr_t'(eth_rx[p].done && eth_rx[p].fcs_bad && big);
        assign inc[B + lsc_pkg::E_RX_FCS] =
            lsc_pkg::lsc_ctr_t'(eth_rx[p].done && eth_rx[p].fcs_bad);
        assign inc[B + lsc_pkg::E_RX_DISC] =
            lsc_pkg::lsc_ctr_t'(eth_rx[p].done && eth_rx[p].no_buf);
        assign inc[B + lsc_pkg::E_RX_FILT] =
            lsc_pkg::lsc_ctr_t'(eth_rx[p].done && eth_rx[p].vlan_unknown);
        assign inc[B + lsc_pkg::E_TX_FRM] = lsc_pkg::lsc_ctr_t'(tgood);
        assign inc[B + lsc_pkg::E_TX_OCT] =
            tgood ? lsc_pkg::lsc_ctr_t'(eth_tx[p].len) : '0;
        assign inc[B + lsc_pkg::E_TX_BC] =
            lsc_pkg::lsc_ctr_t'(tgood && eth_tx[p].bcast);
        assign inc[B + lsc_pkg::E_TX_MC] =
            lsc_pkg::lsc_ctr_t'(tgood && eth_tx[p].mcast);
        assign inc[B + lsc_pkg::E_TX_COL] = lsc_pkg::lsc_ctr_t'(eth_tx[p].collision);
        assign rx_bin = eth_rx[p].done
            ? lsc_pkg::lsc_len_bin(eth_rx[p].len, max_frame_length_limit) : '0;
        assign tx_bin = tgood
            ? lsc_pkg::lsc_len_bin(eth_tx[p].len, max_frame_length_limit) : '0;
        // A receive and a transmit frame may hit the same bin together
        for (genvar b = 0; b < lsc_pkg::HIST_BINS; b++) begin : g_bin
            assign inc[B + lsc_pkg::E_HIST0 + b] =
                lsc_pkg::lsc_ctr_t'(rx_bin[b]) + lsc_pkg::lsc_ctr_t'(tx_bin[b]);
        end

        AST_UNDERSIZE: assert property (@(posedge clk) disable iff (rst)
            (good && short_frm && !clear_all && st_r.cnt[B + lsc_pkg::E_RX_UND] != '1)
            |=> st_r.cnt[B + lsc_pkg::E_RX_UND] == $past(st_r.cnt[B + lsc_pkg::E_RX_UND]) + 1)
            else $error("Undersize frame not counted");
        AST_JABBER: assert property (@(posedge clk) disable iff (rst)
            (!clear_all && !(eth_rx[p].done && eth_rx[p].fcs_bad && big))
            |=> $stable(st_r.cnt[B + lsc_pkg::E_RX_JAB]))
            else $error("Jabber counter moved without a jabber frame");
        AST_HIST64: assert property (@(posedge clk) disable iff (rst)
            (eth_rx[p].done && eth_rx[p].len == lsc_pkg::LEN_64 && !tgood && !clear_all
                && st_r.cnt[B + lsc_pkg::E_HIST0] != '1)
            |=> st_r.cnt[B + lsc_pkg::E_HIST0] == $past(st_r.cnt[B + lsc_pkg::E_HIST0]) + 1)
            else $error("64-byte frame missed its bin");
        AST_FRAGMENT: assert property (@(posedge clk) disable iff (rst)
            (eth_rx[p].done && !eth_rx[p].fcs_bad && !clear_all)
            |=> $stable(st_r.cnt[B + lsc_pkg::E_RX_FRAG]))
            else $error("Fragment counted for a frame with good checksum");
    end

    // One-second slots; the memory read tracks the slot about to be reused
    assign tick = (st_r.sec_cnt == TICK_LAST);
    for (genvar w = 0; w < lsc_pkg::W_N; w++) begin : g_old
        assign old_slot[w] = st_r.slot_vld[st_r.ptr]
            ? ring_rdata[w*lsc_pkg::CW +: lsc_pkg::CW] : '0;
    end

    lsc_ring_mem #(
        .W(MW),
        .AW(lsc_pkg::PTR_W)
    ) u_ring (
        .clk(clk),
        .rst(rst),
        .we(tick),
        .waddr(st_r.ptr),
        .wdata(st_r.bucket),
        .raddr(st_r.ptr),
        .rdata(ring_rdata)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.abort_d = hdlc_rx.abort;
        // Set wins over clear: an event in the clear cycle survives it
        for (int i = 0; i < lsc_pkg::NCTR; i++) begin
            st_nxt.cnt[i] =
                lsc_pkg::lsc_sat_add(clear_all ? '0 : st_r.cnt[i], inc[i]);
        end
        st_nxt.sec_cnt = tick ? 32'h0000_0000 : st_r.sec_cnt + 32'h0000_0001;
        if (tick) begin
            // Drop the slot that falls out of the minute, add the one just closed
            for (int w = 0; w < lsc_pkg::W_N; w++) begin
                st_nxt.win[w] = lsc_pkg::lsc_sat_add(
                    (st_r.win[w] > old_slot[w]) ? st_r.win[w] - old_slot[w] : '0,
                    st_r.bucket[w]);
                st_nxt.bucket[w] = win_add[w];
            end
            st_nxt.slot_vld[st_r.ptr] = 1'b1;
            st_nxt.ptr = (st_r.ptr == lsc_pkg::PTR_LAST) ? '0 : st_r.ptr + 6'h01;
        end else begin
            for (int w = 0; w < lsc_pkg::W_N; w++) begin
                st_nxt.bucket[w] = lsc_pkg::lsc_sat_add(st_r.bucket[w], win_add[w]);
            end
        end
        if (clear_all) begin
            st_nxt.win = '0;
            st_nxt.slot_vld = '0;
            for (int w = 0; w < lsc_pkg::W_N; w++) begin
                st_nxt.bucket[w] = win_add[w];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar q = 0; q < lsc_pkg::NQ; q++) begin : g_q
        lsc_qlevel u_q (
            .clk(clk),
            .rst(rst),
            .clear(clear_all),
            .enq(hdlc_tx.enq[q]),
            .deq(hdlc_tx.deq[q]),
            .level(queue_present_level[q]),
            .peak(queue_peak_level[q])
        );
    end

    assign counters = st_r.cnt;
    assign window_counts = st_r.win;

    AST_RX_TOTAL: assert property (@(posedge clk) disable iff (rst)
        (rx_good && !clear_all && st_r.cnt[lsc_pkg::H_RX_FRM] != '1)
        |=> st_r.cnt[lsc_pkg::H_RX_FRM] == $past(st_r.cnt[lsc_pkg::H_RX_FRM]) + 1)
        else $error("Accepted frame not counted");
    AST_RX_OCTETS: assert property (@(posedge clk) disable iff (rst)
        (rx_good && !clear_all && st_r.cnt[lsc_pkg::H_RX_OCT] < 32'h8000_0000)
        |=> st_r.cnt[lsc_pkg::H_RX_OCT]
            == $past(st_r.cnt[lsc_pkg::H_RX_OCT]) + $past(hdlc_rx.bits[18:3]))
        else $error("Received octets not added");
    AST_NON_BYTE_ALIGNED_ERROR: assert property (@(posedge clk) disable iff (rst)
        (hdlc_rx.done && hdlc_rx.bits[2:0] != 3'h0 && !clear_all
            && st_r.cnt[lsc_pkg::H_RX_NOB] != '1)
        |=> st_r.cnt[lsc_pkg::H_RX_NOB] == $past(st_r.cnt[lsc_pkg::H_RX_NOB]) + 1)
        else $error("Non byte aligned frame not counted");
    AST_ABORT_ONCE: assert property (@(posedge clk) disable iff (rst)
        (hdlc_rx.abort && st_r.abort_d && !clear_all)
        |=> $stable(st_r.cnt[lsc_pkg::H_RX_ABT]))
        else $error("Held abort counted more than once");
    AST_ABORT_RISE: assert property (@(posedge clk) disable iff (rst)
        ($rose(hdlc_rx.abort) && !clear_all && st_r.cnt[lsc_pkg::H_RX_ABT] != '1)
        |=> st_r.cnt[lsc_pkg::H_RX_ABT] == $past(st_r.cnt[lsc_pkg::H_RX_ABT]) + 1)
        else $error("Abort not counted");
    AST_RX_FCS: assert property (@(posedge clk) disable iff (rst)
        (hdlc_rx.done && hdlc_rx.fcs_bad && !clear_all && st_r.cnt[lsc_pkg::H_RX_FCS] != '1)
        |=> st_r.cnt[lsc_pkg::H_RX_FCS] == $past(st_r.cnt[lsc_pkg::H_RX_FCS]) + 1)
        else $error("Checksum error frame not counted");
    AST_RX_OVERRUN: assert property (@(posedge clk) disable iff (rst)
        (hdlc_rx.done && hdlc_rx.no_buf && !clear_all && st_r.cnt[lsc_pkg::H_RX_OVR] != '1)
        |=> st_r.cnt[lsc_pkg::H_RX_OVR] == $past(st_r.cnt[lsc_pkg::H_RX_OVR]) + 1)
        else $error("Dropped frame not counted as overrun");
    AST_UNDERRUN: assert property (@(posedge clk) disable iff (rst)
        (hdlc_tx.done && hdlc_tx.underrun && !clear_all)
        |=> $stable(st_r.cnt[lsc_pkg::H_TX_FRM]))
        else $error("Underrun frame counted as sent");
    AST_SATURATE: assert property (@(posedge clk) disable iff (rst)
        (st_r.cnt[lsc_pkg::H_RX_OCT] == '1 && !clear_all)
        |=> st_r.cnt[lsc_pkg::H_RX_OCT] == '1)
        else $error("Counter wrapped past all ones");
    AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (clear_all && !hdlc_rx.done && !hdlc_rx.evict && !hdlc_rx.abort)
        |=> (st_r.cnt[lsc_pkg::H_RX_FRM] == '0 && st_r.cnt[lsc_pkg::H_RX_EVI] == '0
            && st_r.win == '0))
        else $error("Clear did not zero counters");
    AST_WIN_HOLD: assert property (@(posedge clk) disable iff (rst)
        (!tick && !clear_all) |=> $stable(st_r.win))
        else $error("Window count moved between slot boundaries");
    AST_WIN_SLOT: assert property (@(posedge clk) disable iff (rst)
        (tick && !clear_all) |=> (st_r.ptr == 6'h00 || st_r.ptr == $past(st_r.ptr) + 6'h01)
            && st_r.ptr < lsc_pkg::WIN_SECONDS)
        else $error("Slot pointer left the minute ring");
endmodule : lsc_link_stats

// File: sim/lsc_far_model.sv
`timescale 1ns/1ns
module lsc_far_model (
    // Clock
    input wire logic clk,
    // Framer and MAC events
    output lsc_pkg::lsc_hdlc_rx_t hdlc_rx,
    output lsc_pkg::lsc_hdlc_tx_t hdlc_tx,
    output lsc_pkg::lsc_eth_rx_t [lsc_pkg::ETH_PORTS-1:0] eth_rx,
    output lsc_pkg::lsc_eth_tx_t [lsc_pkg::ETH_PORTS-1:0] eth_tx
);
    initial begin
        hdlc_rx = '0;
        hdlc_tx = '0;
        eth_rx = '0;
        eth_tx = '0;
    end
    // Held n cycles; only the abort level uses n above one, done would count n times
    task automatic hrx(input lsc_pkg::lsc_hdlc_rx_t v, input int n);
        @(posedge clk);
        hdlc_rx <= v;
        repeat (n) @(posedge clk);
        hdlc_rx <= '0;
    endtask : hrx
    task automatic htx(input lsc_pkg::lsc_hdlc_tx_t v);
        @(posedge clk);
        hdlc_tx <= v;
        @(posedge clk);
        hdlc_tx <= '0;
    endtask : htx
    // Second port only; the first stays idle so crosstalk between ports shows
    task automatic erx(input lsc_pkg::lsc_eth_rx_t v);
        @(posedge clk);
        eth_rx[1] <= v;
        @(posedge clk);
        eth_rx[1] <= '0;
    endtask : erx
    task automatic etx(input lsc_pkg::lsc_eth_tx_t v);
        @(posedge clk);
        eth_tx[1] <= v;
        @(posedge clk);
        eth_tx[1] <= '0;
    endtask : etx
endmodule : lsc_far_model

// File: sim/test_lsc_link_stats.sv
`timescale 1ns/1ns
module test_lsc_link_stats;
    localparam int TK = 8;
    logic clk;
    logic rst;
    logic clear_all;
    logic [15:0] max_len;
    lsc_pkg::lsc_hdlc_rx_t hdlc_rx;
    lsc_pkg::lsc_hdlc_tx_t hdlc_tx;
    lsc_pkg::lsc_eth_rx_t [lsc_pkg::ETH_PORTS-1:0] eth_rx;
    lsc_pkg::lsc_eth_tx_t [lsc_pkg::ETH_PORTS-1:0] eth_tx;
    lsc_pkg::lsc_ctr_t [lsc_pkg::NCTR-1:0] ctrs;
    lsc_pkg::lsc_ctr_t [lsc_pkg::W_N-1:0] win;
    logic [lsc_pkg::NQ-1:0][lsc_pkg::QW-1:0] qlev;
    logic [lsc_pkg::NQ-1:0][lsc_pkg::QW-1:0] qpk;
    logic [15:0] e[24] = '{16'h0008, 16'h0DF4, 16'h0006, 16'h078C, 16'h0001, 16'h0001,
        16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
        16'h08FC, 16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h0001, 16'h0001, 16'h0001,
        16'h0001, 16'h0001};
    int fail_count;
    int compares;
    lsc_far_model part_u (.clk(clk), .hdlc_rx(hdlc_rx), .hdlc_tx(hdlc_tx), .eth_rx(eth_rx),
        .eth_tx(eth_tx));
    lsc_link_stats #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .rst(rst), .clear_all(clear_all),
        .hdlc_rx(hdlc_rx), .hdlc_tx(hdlc_tx), .eth_rx(eth_rx), .eth_tx(eth_tx),
        .max_frame_length_limit(max_len), .counters(ctrs), .window_counts(win),
        .queue_present_level(qlev), .queue_peak_level(qpk));
    task automatic chk(input lsc_pkg::lsc_ctr_t seen, input lsc_pkg::lsc_ctr_t exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // Flag fields trail the length in each literal, packed in struct order
    task automatic t_uplink_rx();
        part_u.hrx({1'h1, 19'h0_0040, 4'h0}, 1);
        part_u.hrx({1'h1, 19'h0_0041, 4'h0}, 1);
        part_u.hrx({1'h1, 19'h0_0040, 4'h8}, 1);
        part_u.hrx({1'h1, 19'h0_0010, 4'h0}, 1);
        part_u.hrx({1'h1, 19'h0_0040, 4'h4}, 1);
        part_u.hrx({1'h0, 19'h0_0000, 4'h2}, 5);
        part_u.hrx({1'h0, 19'h0_0000, 4'h1}, 1);
        settle(2);
        for (int i = 0; i < 8; i++) begin
            chk(ctrs[i], i == 1 ? 32'h0000_0008 : 32'h0000_0001);
        end
    endtask : t_uplink_rx
    task automatic t_uplink_tx();
        part_u.htx({1'h1, 16'h000A, 8'h00});
        part_u.htx({1'h1, 16'h0005, 8'h80});
        part_u.htx({1'h0, 16'h0000, 8'h40});
        part_u.htx({1'h0, 16'h0000, 8'h38});
        part_u.htx({1'h0, 16'h0000, 8'h38});
        part_u.htx({1'h0, 16'h0000, 8'h08});
        part_u.htx({1'h0, 16'h0000, 8'h06});
        settle(2);
        for (int i = 0; i < 4; i++) begin
            chk(ctrs[8+i], i == 1 ? 32'h0000_000A : 32'h0000_0001);
        end
        for (int i = 0; i < 3; i++) begin
            chk({16'h0000, qlev[i]}, i == 0 ? 32'h0000_0003 : 32'h0000_0001);
            chk({16'h0000, qpk[i]}, i == 0 ? 32'h0000_0003 : 32'h0000_0002);
        end
    endtask : t_uplink_tx
    // A frame in the clear cycle survives the clear; a second clear then zeroes the accepted frame and octet totals
    task automatic t_clear();
        fork
            part_u.hrx({1'h1, 19'h0_0040, 4'h0}, 1);
            begin
                @(posedge clk) clear_all <= 1'h1;
                @(posedge clk) clear_all <= 1'h0;
            end
        join
        #1;
        for (int i = 0; i < lsc_pkg::NCTR; i++) begin
            chk(ctrs[i], i > 1 ? 32'h0000_0000 : i == 1 ? 32'h0000_0008 : 32'h0000_0001);
        end
        chk({16'h0000, qpk[0]}, 32'h0000_0000);
        settle(1);
        chk({16'h0000, qpk[0]}, 32'h0000_0003);
        @(posedge clk) clear_all <= 1'h1;
        @(posedge clk) clear_all <= 1'h0;
        #1;
        chk(ctrs[0], 32'h0000_0000);
        chk(ctrs[1], 32'h0000_0000);
    endtask : t_clear
    // Window holds whole slots only, so wait two slots in, then past sixty
    task automatic t_window();
        part_u.hrx({1'h1, 19'h0_0040, 4'h0}, 1);
        part_u.htx({1'h1, 16'h000A, 8'h00});
        settle(2 * TK + 2);
        chk(win[0], 32'h0000_0001);
        chk(win[1], 32'h0000_0008);
        chk(win[2], 32'h0000_0001);
        chk(win[3], 32'h0000_000A);
        settle(61 * TK);
        for (int i = 0; i < 4; i++) chk(win[i], 32'h0000_0000);
        chk(ctrs[0], 32'h0000_0001);
    endtask : t_window
    task automatic t_ethernet();
        part_u.erx({1'h1, 16'h0040, 5'h08});
        part_u.erx({1'h1, 16'h0064, 5'h04});
        part_u.erx({1'h1, 16'h0028, 5'h00});
        part_u.erx({1'h1, 16'h0640, 5'h00});
        part_u.erx({1'h1, 16'h0028, 5'h10});
        part_u.erx({1'h1, 16'h0640, 5'h10});
        part_u.erx({1'h1, 16'h0040, 5'h02});
        part_u.erx({1'h1, 16'h0040, 5'h01});
        part_u.etx({1'h1, 16'h00C8, 3'h4});
        part_u.etx({1'h1, 16'h012C, 3'h2});
        part_u.etx({1'h1, 16'h0258, 3'h0});
        part_u.etx({1'h1, 16'h04B0, 3'h0});
        part_u.etx({1'h0, 16'h0000, 3'h1});
        settle(2);
        for (int i = 0; i < 6; i++) chk(ctrs[36+i], {16'h0000, e[i]});
        for (int i = 6; i < 10; i++) chk(ctrs[36+i], {16'h0000, e[i]});
        for (int i = 10; i < 13; i++) chk(ctrs[36+i], {16'h0000, e[i]});
        for (int i = 13; i < 18; i++) chk(ctrs[36+i], {16'h0000, e[i]});
        for (int i = 18; i < 24; i++) chk(ctrs[36+i], {16'h0000, e[i]});
        for (int i = 0; i < 24; i++) chk(ctrs[12+i], 32'h0000_0000);
    endtask : t_ethernet
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Run needs about 590 cycles; the limit leaves ample margin
    initial begin
        #40000;
        fail_count++;
        wrap_up();
    end
    initial begin
        rst = 1'h1;
        clear_all = 1'h0;
        max_len = 16'h05DC;
        fail_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_uplink_rx();
        t_uplink_tx();
        t_clear();
        t_window();
        t_ethernet();
        wrap_up();
    end
endmodule : test_lsc_link_stats
